// [rtl/link_sync_request_select.sv]
// Link sync request source select and bring-up sequencing.
// Assumes config inputs are on i_core_clk; pins are asynchronous.
//
// Behaviour
// - Select 0 takes active-low single-ended request.
// - Request low starts code group synchronisation.
// - Request release starts initial lane alignment.
// - Select 1 takes request from marker pair.
// - SYSREF aligns multiframe counter for latency.
// - Marker pair request is active low.
// - Marker pair ignored while receiver disabled.
// - Marker pair serves marker and request together.
`timescale 1ns/100ps
`include "link_sync_consts.svh"
module link_sync_request_select
  import link_sync_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Sync request pins
  input wire logic i_single_ended_link_sync_pin_n,
  input wire logic i_differential_marker_pair_p,
  input wire logic i_differential_marker_pair_n,
  // Reference pins
  input wire logic i_sysref_p,
  input wire logic i_sysref_n,
  // Configuration
  input wire logic i_sync_source_select,
  input wire logic i_marker_receiver_enable,
  // Link status
  output logic [4:0] o_link_state,
  output logic o_cgs_active,
  output logic o_ilas_active,
  output logic o_data_active,
  output logic o_ilas_start,
  output logic o_sync_request,
  output logic o_lmfc_boundary,
  // Reference and marker events
  output logic o_sysref_edge,
  output logic o_marker_event
);

  ctrl_state_s s_q;
  ctrl_state_s s_d;
  logic req_n;
  logic lmfc_wrap;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pin_sync_if se_if();
  pin_sync_if mk_if();
  pin_sync_if sr_if();

  assign se_if.raw = i_single_ended_link_sync_pin_n;
  assign mk_if.raw = i_differential_marker_pair_p & ~i_differential_marker_pair_n;
  assign sr_if.raw = i_sysref_p & ~i_sysref_n;

  pin_sync u_se_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .io_pin(se_if.filt)
  );

  pin_sync u_mk_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .io_pin(mk_if.filt)
  );

  pin_sync u_sr_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .io_pin(sr_if.filt)
  );

  // ****************************************************************
  // Request source selection, active low
  // ****************************************************************
  always_comb begin
    if (i_sync_source_select == `LSRS_SEL_SINGLE_ENDED) begin
      req_n = se_if.level;
    end else if (i_marker_receiver_enable == `LSRS_RX_ENABLED) begin
      req_n = mk_if.level;
    end else begin
      req_n = 1'b1;
    end
  end

  assign lmfc_wrap = (s_q.lmfc_cnt == `LSRS_LMFC_LAST);

  // ****************************************************************
  // Multiframe counter, bring-up state machine, events
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ilas_start = 1'b0;
    s_d.sync_req = ~req_n;
    s_d.sysref_edge = sr_if.rise;
    s_d.marker_event = mk_if.rise & i_marker_receiver_enable;
    s_d.lmfc_boundary = lmfc_wrap;
    if (sr_if.rise) begin
      s_d.lmfc_cnt = `LSRS_LMFC_RESET;
    end else if (lmfc_wrap) begin
      s_d.lmfc_cnt = `LSRS_LMFC_RESET;
    end else begin
      s_d.lmfc_cnt = s_q.lmfc_cnt + 4'h1;
    end
    if (!req_n) begin
      s_d.state = ST_CGS;
      s_d.ilas_cnt = `LSRS_ILAS_RESET;
    end else begin
      unique case (s_q.state)
        ST_IDLE: begin
          s_d.state = ST_IDLE;
        end
        ST_CGS: begin
          s_d.state = ST_WAIT_LMFC;
        end
        ST_WAIT_LMFC: begin
          if (lmfc_wrap && !sr_if.rise) begin
            s_d.state = ST_ILAS;
            s_d.ilas_start = 1'b1;
            s_d.ilas_cnt = `LSRS_ILAS_RESET;
          end
        end
        ST_ILAS: begin
          if (s_q.ilas_cnt == `LSRS_ILAS_LAST) begin
            s_d.state = ST_DATA;
          end else begin
            s_d.ilas_cnt = s_q.ilas_cnt + 3'h1;
          end
        end
        ST_DATA: begin
          s_d.state = ST_DATA;
        end
        default: begin
          s_d.state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_q <= '{state: ST_IDLE, lmfc_cnt: `LSRS_LMFC_RESET,
               ilas_cnt: `LSRS_ILAS_RESET, ilas_start: 1'b0, sync_req: 1'b0,
               sysref_edge: 1'b0, marker_event: 1'b0, lmfc_boundary: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_link_state = s_q.state;
  assign o_cgs_active = (s_q.state == ST_CGS);
  assign o_ilas_active = (s_q.state == ST_ILAS);
  assign o_data_active = (s_q.state == ST_DATA);
  assign o_ilas_start = s_q.ilas_start;
  assign o_sync_request = s_q.sync_req;
  assign o_lmfc_boundary = s_q.lmfc_boundary;
  assign o_sysref_edge = s_q.sysref_edge;
  assign o_marker_event = s_q.marker_event;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_se_source;
    (i_sync_source_select == 1'b0) && !se_if.level |=> o_cgs_active;
  endproperty
  a_se_source: assert property (p_se_source)
    else $error("single-ended request low did not start CGS");

  property p_cgs_on_low;
    o_data_active && !req_n |=> o_cgs_active && o_sync_request;
  endproperty
  a_cgs_on_low: assert property (p_cgs_on_low)
    else $error("request low did not enter CGS");

  property p_release_wait;
    o_cgs_active && req_n |=> (s_q.state == ST_WAIT_LMFC) && !o_sync_request;
  endproperty
  a_release_wait: assert property (p_release_wait)
    else $error("release did not leave CGS");

  property p_ilas_start;
    (s_q.state == ST_WAIT_LMFC) && lmfc_wrap && req_n && !sr_if.rise
      |=> o_ilas_active && o_ilas_start;
  endproperty
  a_ilas_start: assert property (p_ilas_start)
    else $error("alignment sequence did not start on multiframe edge");

  property p_ilas_length;
    $rose(o_ilas_active) && req_n ##1 req_n [*7] |=> o_data_active;
  endproperty
  a_ilas_length: assert property (p_ilas_length)
    else $error("alignment sequence length wrong");

  property p_pair_source;
    i_sync_source_select && i_marker_receiver_enable && !mk_if.level
      |=> o_cgs_active;
  endproperty
  a_pair_source: assert property (p_pair_source)
    else $error("marker pair low did not start CGS");

  property p_pair_ignored;
    i_sync_source_select && !i_marker_receiver_enable && o_data_active
      |=> o_data_active;
  endproperty
  a_pair_ignored: assert property (p_pair_ignored)
    else $error("disabled marker pair affected link");

  property p_sysref_align;
    sr_if.rise |=> (s_q.lmfc_cnt == 4'h0) ##1 (s_q.lmfc_cnt == 4'h1);
  endproperty
  a_sysref_align: assert property (p_sysref_align)
    else $error("SYSREF did not realign multiframe counter");

  property p_marker_shared;
    i_marker_receiver_enable && mk_if.rise |=> o_marker_event;
  endproperty
  a_marker_shared: assert property (p_marker_shared)
    else $error("marker event lost while pair used as request");

  property p_sync_latency;
    !i_single_ended_link_sync_pin_n [*4] |=> !se_if.level;
  endproperty
  a_sync_latency: assert property (p_sync_latency)
    else $error("synchroniser latency exceeded");

  c_cgs: cover property (o_cgs_active ##1 (s_q.state == ST_WAIT_LMFC));
  c_ilas: cover property ($rose(o_ilas_active));
  c_data: cover property ($rose(o_data_active));
  c_pair_req: cover property (i_sync_source_select && o_marker_event &&
                              (s_q.state == ST_WAIT_LMFC));

endmodule

// [pkg/link_sync_consts.svh]
// Timing counts and reset values for the link sync request control.
// Assumes inclusion by bare name from design files.
`ifndef LINK_SYNC_CONSTS_SVH
`define LINK_SYNC_CONSTS_SVH

// ****************************************************************
// Source select and enable encodings
// ****************************************************************
`define LSRS_SEL_SINGLE_ENDED 1'h0
`define LSRS_SEL_MARKER_PAIR 1'h1
`define LSRS_RX_ENABLED 1'h1

// ****************************************************************
// Multiframe and alignment sequence counts
// ****************************************************************
`define LSRS_LMFC_LAST 4'h7
`define LSRS_LMFC_RESET 4'h0
`define LSRS_ILAS_LAST 3'h7
`define LSRS_ILAS_RESET 3'h0

// ****************************************************************
// Synchroniser reset values
// ****************************************************************
`define LSRS_SYNC_FF_RESET 3'h7
`define LSRS_SYNC_LEVEL_RESET 1'h1

`endif

// [pkg/link_sync_pkg.sv]
// Types for the link sync request control.
// Assumes the consts header is compiled alongside.
package link_sync_pkg;

  // ****************************************************************
  // Link bring-up states
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CGS = 5'h02,
    ST_WAIT_LMFC = 5'h04,
    ST_ILAS = 5'h08,
    ST_DATA = 5'h10
  } link_state_e;

  // ****************************************************************
  // State records
  // ****************************************************************
  typedef struct packed {
    logic [2:0] ff;
    logic level;
    logic rise;
    logic fall;
  } sync_state_s;

  typedef struct packed {
    link_state_e state;
    logic [3:0] lmfc_cnt;
    logic [2:0] ilas_cnt;
    logic ilas_start;
    logic sync_req;
    logic sysref_edge;
    logic marker_event;
    logic lmfc_boundary;
  } ctrl_state_s;

endpackage

// [pkg/pin_sync_if.sv]
// Carrier between a pin synchroniser and its user.
// Assumes a single clock domain on the user side.
`timescale 1ns/100ps
interface pin_sync_if;
  logic raw;
  logic level;
  logic rise;
  logic fall;
  modport filt (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface

// [rtl/pin_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes raw input is asynchronous to i_core_clk.
`timescale 1ns/100ps
`include "link_sync_consts.svh"
module pin_sync
  import link_sync_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Filtered pin
  pin_sync_if.filt io_pin
);

  sync_state_s s_q;
  sync_state_s s_d;

  // ****************************************************************
  // Filter: level moves once stages two and three agree
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ff = {s_q.ff[1:0], io_pin.raw};
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    if (s_q.ff[1] == s_q.ff[2] && s_q.ff[2] != s_q.level) begin
      s_d.level = s_q.ff[2];
      s_d.rise = s_q.ff[2];
      s_d.fall = ~s_q.ff[2];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_q <= '{ff: `LSRS_SYNC_FF_RESET, level: `LSRS_SYNC_LEVEL_RESET,
               rise: 1'b0, fall: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign io_pin.level = s_q.level;
  assign io_pin.rise = s_q.rise;
  assign io_pin.fall = s_q.fall;

endmodule

// [dv/lsrs_rx_model.sv]
// Behavioural receiver driving the link sync request.
// Assumes one-cycle i_start with i_use_pair and i_hold steady.
`timescale 1ns/100ps
module lsrs_rx_model (
  // Clock
  input wire logic i_core_clk,
  // Commands
  input wire logic i_start,
  input wire logic i_use_pair,
  input wire logic [3:0] i_hold,
  // Request lines
  output logic o_se_n,
  output logic o_pair_p,
  output logic o_pair_n
);
  logic req_n = 1'b1;
  logic pair_q = 1'b0;
  logic flip = 1'b0;
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;

  // ********
  // Request low, hold, release
  // ********
  always @(posedge i_core_clk) begin
    flip <= ~flip;
    if (i_start && !busy) begin
      busy <= 1'b1;
      pair_q <= i_use_pair;
      cnt <= i_hold;
      req_n <= 1'b0;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      req_n <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end

  // Unused line toggles each cycle
  assign o_se_n = pair_q ? flip : req_n;
  assign o_pair_p = pair_q ? req_n : flip;
  assign o_pair_n = pair_q ? ~req_n : ~flip;
endmodule

// [dv/test_link_sync_request_select.sv]
// Bench for the link sync request control.
// Assumes the receiver model and the design files are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module test_link_sync_request_select
  import link_sync_pkg::*;
;
  logic clk, i_rst_n, start, use_pair, sel, en, sys_p, sys_n, mk, se_n, pp, pn, hit;
  logic [3:0] hold_v;
  logic [4:0] o_link_state;
  logic o_cgs_active, o_ilas_active, o_data_active, o_ilas_start;
  logic o_sync_request, o_lmfc_boundary, o_sysref_edge, o_marker_event;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'hd36e;

  always #50 clk = ~clk;

  lsrs_rx_model u_lsrs_rx_model (.i_core_clk(clk), .i_start(start),
    .i_use_pair(use_pair), .i_hold(hold_v), .o_se_n(se_n), .o_pair_p(pp), .o_pair_n(pn));

  link_sync_request_select u_link_sync_request_select (.i_core_clk(clk),
    .i_rst_n(i_rst_n), .i_single_ended_link_sync_pin_n(se_n),
    .i_differential_marker_pair_p(pp), .i_differential_marker_pair_n(pn),
    .i_sysref_p(sys_p), .i_sysref_n(sys_n), .i_sync_source_select(sel),
    .i_marker_receiver_enable(en), .o_link_state(o_link_state),
    .o_cgs_active(o_cgs_active), .o_ilas_active(o_ilas_active),
    .o_data_active(o_data_active), .o_ilas_start(o_ilas_start),
    .o_sync_request(o_sync_request), .o_lmfc_boundary(o_lmfc_boundary),
    .o_sysref_edge(o_sysref_edge), .o_marker_event(o_marker_event));

  // ********
  // Tasks
  // ********
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic need(input logic h);
    if (h !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic wait_sig(input int which, input int lim, output logic h);
    h = 1'b0;
    for (int n = 0; n < lim && !h; n++) begin
      mk = mk | (o_marker_event === 1'b1);
      case (which)
        0: h = (o_cgs_active === 1'b1);
        1: h = (o_ilas_start === 1'b1);
        default: h = (o_sysref_edge === 1'b1);
      endcase
      if (!h) @(negedge clk);
    end
  endtask

  task automatic request(input logic pair, input logic [3:0] hold);
    use_pair = pair;
    hold_v = hold;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic bring_up(input logic s, input logic full);
    sel = s;
    mk = 1'b0;
    request(s, 4'h6 + 4'($random(seed) & 7));
    wait_sig(0, 20, hit);
    need(hit);
    `CHK(o_link_state, ST_CGS)
    `CHK(o_cgs_active, 1'b1)
    `CHK(o_sync_request, 1'b1)
    wait_sig(1, 40, hit);
    need(hit);
    `CHK(o_link_state, ST_ILAS)
    `CHK(o_ilas_active, 1'b1)
    `CHK(o_sync_request, 1'b0)
    if (s) `CHK(mk, 1'b1)
    if (full) begin
      repeat (7) @(negedge clk);
      `CHK(o_link_state, ST_ILAS)
      `CHK(o_ilas_start, 1'b0)
      @(negedge clk);
      `CHK(o_link_state, ST_DATA)
      `CHK(o_data_active, 1'b1)
    end
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    clk = 1'b0;
    i_rst_n = 1'b0;
    {start, use_pair, sel, sys_p, mk} = 5'h00;
    {en, sys_n} = 2'h3;
    hold_v = 4'h0;
    repeat (20) @(negedge clk);
    i_rst_n = 1'b1;
    `CHK(o_link_state, ST_IDLE)
    `CHK(o_sync_request, 1'b0)
    request(1'b0, 4'h0);
    wait_sig(0, 12, hit);
    `CHK(hit, 1'b0)
    for (int k = 0; k < 2; k++) begin
      sel = k[0];
      en = ~k[0];
      mk = 1'b0;
      request(1'b1, 4'h8);
      wait_sig(0, 20, hit);
      `CHK(hit, 1'b0)
      if (k == 1) `CHK(mk, 1'b0)
    end
    en = 1'b1;
    for (int k = 0; k < 3; k++) begin
      repeat (4 + ($random(seed) & 7)) @(negedge clk);
      {sys_p, sys_n} = 2'h2;
      wait_sig(2, 10, hit);
      need(hit);
      repeat (7) @(negedge clk);
      `CHK(o_lmfc_boundary, 1'b0)
      `CHK(o_sysref_edge, 1'b0)
      @(negedge clk);
      `CHK(o_lmfc_boundary, 1'b1)
      {sys_p, sys_n} = 2'h1;
    end
    for (int i = 0; i < 6; i++) begin
      bring_up(i[0], (i % 3) != 1);
    end
    en = 1'b0;
    mk = 1'b0;
    request(1'b1, 4'h6);
    wait_sig(0, 20, hit);
    `CHK(hit, 1'b0)
    `CHK(o_link_state, ST_DATA)
    `CHK(mk, 1'b0)
    stop_test();
  end
endmodule
